// ---- core/sbd_params.svh ----
// Constants of the buffer diagnostic command interpreter.
// Assumes inclusion by the package and the core module only.
`ifndef SBD_PARAMS_SVH
`define SBD_PARAMS_SVH

// -----------------------------------------------------------------
// Command descriptor block layout
// -----------------------------------------------------------------
`define SBD_CDB_LEN      4'ha
`define SBD_CDB_LAST     4'h9
`define SBD_CDB_SHARED   4'h6
`define SBD_OP_WRBUF     8'h3b
`define SBD_OP_RDBUF     8'h3c
`define SBD_BY_OPCODE    0
`define SBD_BY_MODE      1
`define SBD_BY_BUFID     2
`define SBD_BY_OFF_MSB   3
`define SBD_BY_LEN_MSB   6
`define SBD_MODE_LSB     0

// -----------------------------------------------------------------
// Mode encodings, sense keys and header layout
// -----------------------------------------------------------------
`define SBD_MODE_COMB    2'h0
`define SBD_MODE_DESC    2'h3
`define SBD_SK_NONE      4'h0
`define SBD_SK_ILLEGAL   4'h5
`define SBD_HDR_LEN      24'h000004
`define SBD_DESC_BOUND   8'hff
`define SBD_HDR_RSVD     8'h00

`endif

// ---- core/sbd_pkg.sv ----
// Types shared by the buffer diagnostic command interpreter.
// Assumes the constants header sits beside it.
package sbd_pkg;
    `include "sbd_params.svh"

    typedef logic [23:0] sbd_len_t;

    typedef enum logic [1:0] {
        SBD_CDB,
        SBD_DEC,
        SBD_DOUT,
        SBD_DIN
    } sbd_state_e;
endpackage : sbd_pkg

// ---- core/sbd_core.sv ----
// Buffer write/read diagnostic command interpreter with its own buffer.
// Assumes the initiator-facing logic runs on clk_i and feeds bytes by
// valid/ready handshakes; the medium is never reached from here.
`timescale 1ns/10ps
`include "sbd_params.svh"

module sbd_core #(
    parameter int unsigned CAP     = 2048,
    parameter bit          DESC_EN = 1'b0
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Command descriptor bytes
    input  wire logic             cdb_valid_i,
    input  wire logic [7:0]       cdb_byte_i,
    output logic                  cdb_ready_o,
    // Data out phase
    input  wire logic             dout_valid_i,
    input  wire logic [7:0]       dout_byte_i,
    output logic                  dout_ready_o,
    // Data in phase
    input  wire logic             din_ready_i,
    output logic                  din_valid_o,
    output logic [7:0]            din_byte_o,
    // Completion status
    output logic                  done_o,
    output logic                  check_o,
    output logic [3:0]            sense_key_o
);
    import sbd_pkg::*;

    localparam int unsigned AW  = $clog2(CAP);
    localparam logic [24:0] LIM = 25'(CAP + 4);
    localparam sbd_len_t    CAPL = 24'(CAP);

    if (CAP < 8 || CAP > 32'h00fffff0) begin : g_cap_check
        $error("sbd_core: CAP out of range");
    end

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    sbd_state_e      state_ff, nxt_state;
    logic [7:0]      cdb_ff [10];
    logic [7:0]      nxt_cdb [10];
    logic [3:0]      idx_ff, nxt_idx;
    sbd_len_t        cnt_ff, nxt_cnt;
    sbd_len_t        tot_ff, nxt_tot;
    logic            desc_ff, nxt_desc;
    logic            cdb_rdy_ff, nxt_cdb_rdy;
    logic            dout_rdy_ff, nxt_dout_rdy;
    logic            din_vld_ff, nxt_din_vld;
    logic [7:0]      din_byte_ff, nxt_din_byte;
    logic            done_ff, nxt_done;
    logic            check_ff, nxt_check;
    logic [3:0]      sense_ff, nxt_sense;

    logic [7:0]      mem [CAP];
    logic            mem_we;
    logic [AW-1:0]   mem_addr;
    logic [7:0]      mem_wdata;

    logic [7:0]      opcode;
    logic [1:0]      mode;
    logic [7:0]      buf_id;
    sbd_len_t        offset;
    sbd_len_t        length;
    logic [24:0]     span;

    assign opcode = cdb_ff[`SBD_BY_OPCODE];
    assign mode   = cdb_ff[`SBD_BY_MODE][`SBD_MODE_LSB +: 2];
    assign buf_id = cdb_ff[`SBD_BY_BUFID];
    assign offset = {cdb_ff[`SBD_BY_OFF_MSB], cdb_ff[`SBD_BY_OFF_MSB+1],
                     cdb_ff[`SBD_BY_OFF_MSB+2]};
    assign length = {cdb_ff[`SBD_BY_LEN_MSB], cdb_ff[`SBD_BY_LEN_MSB+1],
                     cdb_ff[`SBD_BY_LEN_MSB+2]};
    assign span   = {1'b0, offset} + {1'b0, length};

    // -----------------------------------------------------------------
    // Byte served at a given position of the data in stream
    // -----------------------------------------------------------------
    function automatic logic [7:0] src_byte(input sbd_len_t pos, input logic desc,
                                            input logic id_ok);
        logic [7:0] b;
        b = 8'h00;
        if (desc) begin
            if (id_ok) begin
                unique case (pos[1:0])
                    2'h0: b = `SBD_DESC_BOUND;
                    2'h1: b = CAPL[23:16];
                    2'h2: b = CAPL[15:8];
                    2'h3: b = CAPL[7:0];
                endcase
            end
        end else if (pos < `SBD_HDR_LEN) begin
            unique case (pos[1:0])
                2'h0: b = `SBD_HDR_RSVD;
                2'h1: b = CAPL[23:16];
                2'h2: b = CAPL[15:8];
                2'h3: b = CAPL[7:0];
            endcase
        end else begin
            b = mem[AW'(pos - `SBD_HDR_LEN)];
        end
        return b;
    endfunction : src_byte

    // -----------------------------------------------------------------
    // Next-state logic
    // -----------------------------------------------------------------
    always_comb begin
        nxt_state    = state_ff;
        nxt_cdb      = cdb_ff;
        nxt_idx      = idx_ff;
        nxt_cnt      = cnt_ff;
        nxt_tot      = tot_ff;
        nxt_desc     = desc_ff;
        nxt_cdb_rdy  = cdb_rdy_ff;
        nxt_dout_rdy = dout_rdy_ff;
        nxt_din_vld  = din_vld_ff;
        nxt_din_byte = din_byte_ff;
        nxt_done     = 1'b0;
        nxt_check    = check_ff;
        nxt_sense    = sense_ff;
        mem_we       = 1'b0;
        mem_addr     = '0;
        mem_wdata    = 8'h00;
        unique case (state_ff)
            SBD_CDB: begin
                if (cdb_valid_i && cdb_rdy_ff) begin
                    nxt_cdb[idx_ff] = cdb_byte_i;
                    if (idx_ff < `SBD_CDB_SHARED) begin
                        mem_we    = 1'b1;
                        mem_addr  = AW'(idx_ff);
                        mem_wdata = cdb_byte_i;
                    end
                    if (idx_ff == `SBD_CDB_LAST) begin
                        nxt_idx     = 4'h0;
                        nxt_cdb_rdy = 1'b0;
                        nxt_state   = SBD_DEC;
                    end else begin
                        nxt_idx = idx_ff + 4'h1;
                    end
                end
            end
            SBD_DEC: begin
                nxt_cnt   = '0;
                nxt_desc  = 1'b0;
                nxt_done  = 1'b1;
                nxt_check = 1'b1;
                nxt_sense = `SBD_SK_ILLEGAL;
                nxt_state = SBD_CDB;
                nxt_cdb_rdy = 1'b1;
                if (opcode == `SBD_OP_WRBUF) begin
                    if (mode != `SBD_MODE_COMB) begin
                        nxt_check = 1'b1;
                    end else if (buf_id != 8'h00 || offset != '0) begin
                        nxt_check = 1'b1;
                    end else if (span > LIM) begin
                        nxt_check = 1'b1;
                    end else begin
                        nxt_check = 1'b0;
                        nxt_sense = `SBD_SK_NONE;
                        if (length != '0) begin
                            nxt_done     = 1'b0;
                            nxt_cdb_rdy  = 1'b0;
                            nxt_tot      = length;
                            nxt_dout_rdy = 1'b1;
                            nxt_state    = SBD_DOUT;
                        end
                    end
                end else if (opcode == `SBD_OP_RDBUF) begin
                    if (mode == `SBD_MODE_COMB ||
                        (DESC_EN && mode == `SBD_MODE_DESC)) begin
                        nxt_check = 1'b0;
                        nxt_sense = `SBD_SK_NONE;
                        nxt_desc  = (mode == `SBD_MODE_DESC);
                        if (mode == `SBD_MODE_DESC) begin
                            nxt_tot = (length < `SBD_HDR_LEN) ? length : `SBD_HDR_LEN;
                        end else begin
                            nxt_tot = ({1'b0, length} < LIM) ? length : 24'(LIM);
                        end
                        if (length != '0) begin
                            nxt_done     = 1'b0;
                            nxt_cdb_rdy  = 1'b0;
                            nxt_din_vld  = 1'b1;
                            nxt_din_byte = src_byte('0, nxt_desc, buf_id == 8'h00);
                            nxt_state    = SBD_DIN;
                        end
                    end
                end
            end
            SBD_DOUT: begin
                if (dout_valid_i && dout_rdy_ff) begin
                    if (cnt_ff >= `SBD_HDR_LEN) begin
                        mem_we    = 1'b1;
                        mem_addr  = AW'(cnt_ff - `SBD_HDR_LEN);
                        mem_wdata = dout_byte_i;
                    end
                    nxt_cnt = cnt_ff + 24'h000001;
                    if (nxt_cnt == tot_ff) begin
                        nxt_dout_rdy = 1'b0;
                        nxt_done     = 1'b1;
                        nxt_cdb_rdy  = 1'b1;
                        nxt_state    = SBD_CDB;
                    end
                end
            end
            SBD_DIN: begin
                if (din_ready_i) begin
                    nxt_cnt = cnt_ff + 24'h000001;
                    if (nxt_cnt == tot_ff) begin
                        nxt_din_vld = 1'b0;
                        nxt_done    = 1'b1;
                        nxt_cdb_rdy = 1'b1;
                        nxt_state   = SBD_CDB;
                    end else begin
                        nxt_din_byte = src_byte(nxt_cnt, desc_ff, buf_id == 8'h00);
                    end
                end
            end
        endcase
    end

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff    <= SBD_CDB;
            for (int i = 0; i < 10; i++) begin
                cdb_ff[i] <= 8'h00;
            end
            idx_ff      <= 4'h0;
            cnt_ff      <= '0;
            tot_ff      <= '0;
            desc_ff     <= 1'b0;
            cdb_rdy_ff  <= 1'b1;
            dout_rdy_ff <= 1'b0;
            din_vld_ff  <= 1'b0;
            din_byte_ff <= 8'h00;
            done_ff     <= 1'b0;
            check_ff    <= 1'b0;
            sense_ff    <= `SBD_SK_NONE;
        end else begin
            state_ff    <= nxt_state;
            cdb_ff      <= nxt_cdb;
            idx_ff      <= nxt_idx;
            cnt_ff      <= nxt_cnt;
            tot_ff      <= nxt_tot;
            desc_ff     <= nxt_desc;
            cdb_rdy_ff  <= nxt_cdb_rdy;
            dout_rdy_ff <= nxt_dout_rdy;
            din_vld_ff  <= nxt_din_vld;
            din_byte_ff <= nxt_din_byte;
            done_ff     <= nxt_done;
            check_ff    <= nxt_check;
            sense_ff    <= nxt_sense;
        end
    end

    // The buffer has no reset; its content is undefined until written.
    // Buffer only, no medium
    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end
    end

    assign cdb_ready_o  = cdb_rdy_ff;
    assign dout_ready_o = dout_rdy_ff;
    assign din_valid_o  = din_vld_ff;
    assign din_byte_o   = din_byte_ff;
    assign done_o       = done_ff;
    assign check_o      = check_ff;
    assign sense_key_o  = sense_ff;

endmodule : sbd_core

// ---- bench/sbd_core_assertions.sv ----
// Port checks for the buffer command interpreter.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module sbd_core_chk #(
    parameter int unsigned CAP = 2048
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       cdb_valid_i,
    input  wire logic       cdb_ready_o,
    input  wire logic       dout_ready_o,
    input  wire logic       din_ready_i,
    input  wire logic       din_valid_o,
    input  wire logic [7:0] din_byte_o,
    input  wire logic       done_o,
    input  wire logic       check_o,
    input  wire logic [3:0] sense_key_o
);
    logic [3:0]  cdb_n_ff;
    logic [3:0]  nxt_cdb_n;
    logic [24:0] din_n_ff;
    logic [24:0] nxt_din_n;

    // The data-in count restarts at each completion, so it indexes the read bytes.
    always_comb begin
        nxt_cdb_n = (cdb_n_ff == 4'h9) ? 4'h0 : cdb_n_ff + 4'h1;
        nxt_din_n = din_n_ff + 25'h1;
        if (!(cdb_valid_i && cdb_ready_o))
            nxt_cdb_n = cdb_n_ff;
        if (!(din_valid_o && din_ready_i))
            nxt_din_n = din_n_ff;
        if (rst_i || done_o)
            nxt_din_n = 25'h0;
        if (rst_i)
            nxt_cdb_n = 4'h0;
    end

    always_ff @(posedge clk_i) begin
        cdb_n_ff <= nxt_cdb_n;
        din_n_ff <= nxt_din_n;
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_sense_code: assert property (
        done_o |-> sense_key_o == (check_o ? 4'h5 : 4'h0))
        else $error("sense key disagrees with status");
    // An accepted command with a data phase clears the status as the phase opens.
    chk_status_hold: assert property (
        !done_o && !$rose(dout_ready_o) && !$rose(din_valid_o) |-> $stable(check_o))
        else $error("status moved without completion");
    chk_din_hold: assert property (
        din_valid_o && !din_ready_i |=> din_valid_o && $stable(din_byte_o))
        else $error("data-in byte dropped while stalled");
    chk_reject_quiet: assert property (
        done_o && check_o |-> !$past(dout_ready_o) && !$past(din_valid_o))
        else $error("rejected command had a data phase");
    chk_cdb_decode: assert property (
        cdb_valid_i && cdb_ready_o && cdb_n_ff == 4'h9 |=>
        !cdb_ready_o ##1 (done_o || dout_ready_o || din_valid_o))
        else $error("command not decoded in two cycles");
    chk_din_bound: assert property (
        din_valid_o |-> din_n_ff < CAP + 4)
        else $error("data-in ran past header plus capacity");
    chk_hdr_first: assert property (
        din_valid_o && din_n_ff == 25'h0 |-> din_byte_o inside {8'h00, 8'hff})
        else $error("first read byte wrong");
    chk_hdr_len: assert property (
        din_valid_o && din_n_ff == 25'h3 |-> din_byte_o inside {8'(CAP), 8'h00})
        else $error("length low byte wrong");
endmodule : sbd_core_chk

bind sbd_core sbd_core_chk #(.CAP(CAP)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cdb_valid_i(cdb_valid_i), .cdb_ready_o(cdb_ready_o),
    .dout_ready_o(dout_ready_o), .din_ready_i(din_ready_i), .din_valid_o(din_valid_o),
    .din_byte_o(din_byte_o), .done_o(done_o), .check_o(check_o), .sense_key_o(sense_key_o)
);

// ---- bench/sbd_initiator.sv ----
// Initiator model for command, data-out and data-in handshakes.
// Assumes the bench calls cmd just after an edge, then reads got and status.
`timescale 1ns/10ps
module sbd_initiator (
    // Clock
    input  wire logic       clk_i,
    // Towards the target
    output logic            cdb_valid_o,
    output logic [7:0]      cdb_byte_o,
    output logic            dout_valid_o,
    output logic [7:0]      dout_byte_o,
    output logic            din_ready_o,
    // From the target
    input  wire logic       cdb_ready_i,
    input  wire logic       dout_ready_i,
    input  wire logic       din_valid_i,
    input  wire logic [7:0] din_byte_i,
    input  wire logic       done_i,
    input  wire logic       check_i,
    input  wire logic [3:0] sense_key_i
);
    logic [7:0] got[$];
    logic       st_chk;
    logic [3:0] st_sk;
    bit         slow = 1'b0;

    initial begin
        {cdb_valid_o, dout_valid_o, din_ready_o} = 3'h0;
        {cdb_byte_o, dout_byte_o} = 16'h0;
    end

    // Holds the byte until ready is seen high at an edge.
    task automatic put(input bit dat, input logic [7:0] b);
        logic ok;
        if (dat) begin
            dout_valid_o = 1'b1;
            dout_byte_o = b;
        end else begin
            cdb_valid_o = 1'b1;
            cdb_byte_o = b;
        end
        do begin
            ok = dat ? dout_ready_i : cdb_ready_i;
            @(posedge clk_i);
            #1;
        end while (!ok);
    endtask : put

    task automatic cmd(input logic [7:0] op, input logic [1:0] md, input logic [7:0] id,
                       input logic [23:0] off, input logic [23:0] len, input int nout,
                       input logic [7:0] base);
        logic [7:0] cdb[10] = '{op, {6'h0, md}, id, off[23:16], off[15:8], off[7:0],
                                len[23:16], len[15:8], len[7:0], 8'h00};
        logic       take;
        logic [7:0] seen;
        got.delete();
        foreach (cdb[i])
            put(1'b0, cdb[i]);
        // Released lines show the inverse of their last byte.
        cdb_valid_o = 1'b0;
        cdb_byte_o = ~cdb_byte_o;
        for (int k = 0; k < nout; k++)
            put(1'b1, k < 4 ? 8'h00 : base + 8'(k - 4));
        dout_valid_o = 1'b0;
        dout_byte_o = ~dout_byte_o;
        // The byte is kept only when valid and ready both stand at the coming edge.
        while (!done_i) begin
            din_ready_o = slow ? !din_ready_o : 1'b1;
            take = din_valid_i && din_ready_o;
            seen = din_byte_i;
            @(posedge clk_i);
            #1;
            if (take)
                got.push_back(seen);
        end
        st_chk = check_i;
        st_sk = sense_key_i;
        din_ready_o = 1'b0;
    endtask : cmd
endmodule : sbd_initiator

// ---- bench/test_scsi_buffer_diag_cmds.sv ----
// Self-checking bench for the buffer diagnostic command interpreter.
// Assumes the initiator model and the bound checker are compiled before it.
`timescale 1ns/10ps
module test_scsi_buffer_diag_cmds;
    localparam int CAP = 16;
    logic       clk_i, rst_i, cdb_valid_i, cdb_ready_o, dout_valid_i, dout_ready_o;
    logic       din_ready_i, din_valid_o, done_o, check_o;
    logic [7:0] cdb_byte_i, dout_byte_i, din_byte_o;
    logic [3:0] sense_key_o;
    int         n_errors = 0;
    int         check_count = 0;
    int         cycles = 0;

    sbd_core #(.CAP(CAP), .DESC_EN(1'b1)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .cdb_valid_i(cdb_valid_i), .cdb_byte_i(cdb_byte_i),
        .cdb_ready_o(cdb_ready_o), .dout_valid_i(dout_valid_i), .dout_byte_i(dout_byte_i),
        .dout_ready_o(dout_ready_o), .din_ready_i(din_ready_i), .din_valid_o(din_valid_o),
        .din_byte_o(din_byte_o), .done_o(done_o), .check_o(check_o), .sense_key_o(sense_key_o)
    );
    sbd_initiator init (
        .clk_i(clk_i), .cdb_valid_o(cdb_valid_i), .cdb_byte_o(cdb_byte_i),
        .dout_valid_o(dout_valid_i), .dout_byte_o(dout_byte_i), .din_ready_o(din_ready_i),
        .cdb_ready_i(cdb_ready_o), .dout_ready_i(dout_ready_o), .din_valid_i(din_valid_o),
        .din_byte_i(din_byte_o), .done_i(done_o), .check_i(check_o), .sense_key_i(sense_key_o)
    );

    task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic st(input logic c, input logic [3:0] k);
        check("check", {23'h0, init.st_chk}, {23'h0, c});
        check("sense", {20'h0, init.st_sk}, {20'h0, k});
    endtask : st

    task automatic check_rd(input logic [7:0] exp[$]);
        check("count", 24'(init.got.size()), 24'(exp.size()));
        foreach (exp[i])
            check("byte", {16'h0, init.got[i]}, {16'h0, exp[i]});
    endtask : check_rd

    task automatic t_wr_rd();
        logic [7:0] e[$] = '{8'h00, 8'h00, 8'h00, 8'(CAP),
                             8'h3c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        init.cmd(8'h3b, 2'h0, 8'h00, 24'h0, 24'(CAP + 4), CAP + 4, 8'h40);
        st(1'b0, 4'h0);
        init.slow = 1'b1;
        init.cmd(8'h3c, 2'h0, 8'h00, 24'h0, 24'd40, 0, 8'h00);
        init.slow = 1'b0;
        for (int j = 6; j < CAP; j++)
            e.push_back(8'h40 + 8'(j));
        check_rd(e);
    endtask : t_wr_rd

    task automatic t_reject();
        init.cmd(8'h3b, 2'h0, 8'h00, 24'h0, 24'(CAP + 5), 0, 8'h00);
        st(1'b1, 4'h5);
        init.cmd(8'h3b, 2'h0, 8'h01, 24'h0, 24'd8, 0, 8'h00);
        st(1'b1, 4'h5);
        init.cmd(8'h3b, 2'h0, 8'h00, 24'h1, 24'(CAP + 4), 0, 8'h00);
        st(1'b1, 4'h5);
        for (int m = 1; m < 4; m++) begin
            init.cmd(8'h3b, 2'(m), 8'h00, 24'h0, 24'd8, 0, 8'h00);
            st(1'b1, 4'h5);
            init.cmd(8'h3c, 2'(m - 1), 8'h00, 24'h0, 24'd8, 0, 8'h00);
            check(m == 1 ? "no check" : "check", {23'h0, init.st_chk}, {23'h0, m > 1});
        end
    endtask : t_reject

    task automatic t_alloc();
        logic [7:0] e[$];
        init.cmd(8'h3c, 2'h0, 8'h00, 24'h0, 24'h0, 0, 8'h00);
        st(1'b0, 4'h0);
        check_rd(e);
        init.cmd(8'h3b, 2'h0, 8'h00, 24'h0, 24'd8, 8, 8'h80);
        st(1'b0, 4'h0);
        init.cmd(8'h3c, 2'h0, 8'h05, 24'h7, 24'd12, 0, 8'h00);
        st(1'b0, 4'h0);
        e = '{8'h00, 8'h00, 8'h00, 8'(CAP), 8'h3c, 8'h00,
              8'h05, 8'h00, 8'h00, 8'h07, 8'h46, 8'h47};
        check_rd(e);
    endtask : t_alloc

    task automatic t_desc();
        init.cmd(8'h3c, 2'h3, 8'h00, 24'h0, 24'd10, 0, 8'h00);
        check_rd('{8'hff, 8'h00, 8'h00, 8'(CAP)});
        init.cmd(8'h3c, 2'h3, 8'h02, 24'h0, 24'd2, 0, 8'h00);
        check_rd('{8'h00, 8'h00});
    endtask : t_desc

    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            wrap_up();
        end
    end

    initial begin
        rst_i = 1'b1;
        repeat (16) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        t_wr_rd();
        t_reject();
        t_alloc();
        t_desc();
        wrap_up();
    end
endmodule : test_scsi_buffer_diag_cmds
